// >>> inc/bcalc_defines.svh
// Constants of the byte arithmetic and logic core
// Function
// - Direct mode reaches internal RAM, special registers
// - Indirect address from R0, R1 or pointer
// - Register mode picks bank working register
// - Immediate bytes are values, not addresses
// - Implied operand such as accumulator
// - Indexed code read: pointer plus accumulator
// - Bit mode selects one of 256 bits
// - Add timing per addressing form
// - Add with carry adds carry, same timing
// - Subtract with borrow, same timing table
// - Increment and decrement timing per form
// - Multiply is one byte, two cycles
// - Divide is one byte, six cycles
// - Logic operations act per bit
// - Logic into accumulator timing per form
// - Logic into direct byte timing
// - Rotates, clear, complement: one byte, cycle
// - Nibble swap: one byte, one cycle
// - Moves between internal locations, except register to register or to/from @R0/@R1
// - External moves: accumulator only, indirect only
// - Lookup tables read code memory indexed
`ifndef BCALC_DEFINES_SVH
`define BCALC_DEFINES_SVH
// Reset values
`define BC_RST_BYTE 8'h00
`define BC_RST_WORD 16'h0000
// Special register addresses in the upper direct space, and the bit RAM base below it
`define BC_ADR_HIGH 8'h80
`define BC_ADR_ACC 8'hE0
`define BC_ADR_B 8'hF0
`define BC_ADR_PSW 8'hD0
`define BC_ADR_DPL 8'h82
`define BC_ADR_DPH 8'h83
`define BC_BITRAM_BASE 8'h20
// Opcode high nibbles of the grouped forms
`define BC_HI_INC 4'h0
`define BC_HI_DECR 4'h1
`define BC_HI_ADD 4'h2
`define BC_HI_ADDWC 4'h3
`define BC_HI_OR 4'h4
`define BC_HI_AND 4'h5
`define BC_HI_XOR 4'h6
`define BC_HI_MOVI 4'h7
`define BC_HI_MOVD 4'h8
`define BC_HI_SUBWB 4'h9
`define BC_HI_MOVR 4'hA
`define BC_HI_MOVA 4'hE
`define BC_HI_MOVFA 4'hF
// Operand forms in the low nibble
`define BC_LO_IMM 4'h4
`define BC_LO_DIR 4'h5
// Single opcodes
`define BC_OP_RR 8'h03
`define BC_OP_RORC 8'h13
`define BC_OP_RL 8'h23
`define BC_OP_ROLC 8'h33
`define BC_OP_SWAP 8'hC4
`define BC_OP_CLRA 8'hE4
`define BC_OP_CPLA 8'hF4
`define BC_OP_INCDP 8'hA3
`define BC_OP_MULT 8'hA4
`define BC_OP_DIVIDE 8'h84
`define BC_OP_LDDP 8'h90
`define BC_OP_TABLE 8'h93
`define BC_OP_MOVAI 8'h74
`define BC_OP_MOVDI 8'h75
`define BC_OP_MOVDD 8'h85
`define BC_OP_BITCPL 8'hB2
`define BC_OP_BITCLR 8'hC2
`define BC_OP_BITSET 8'hD2
// Instruction lengths and cycle counts
`define BC_LEN_1 2'h1
`define BC_LEN_2 2'h2
`define BC_LEN_3 2'h3
`define BC_CYC_1 3'h1
`define BC_CYC_2 3'h2
`define BC_CYC_3 3'h3
`define BC_CYC_4 3'h4
`define BC_CYC_5 3'h5
`define BC_CYC_6 3'h6
`endif

// >>> inc/bcalc_pkg.sv
// Types shared by the byte arithmetic and logic core
package bcalc_pkg;
   typedef struct packed {logic cy; logic ac; logic f0; logic [1:0] rs; logic ov; logic f1; logic p;} bcalc_psw_t;
   typedef struct packed {logic [1:0] len; logic [2:0] cyc;} bcalc_timing_t;
   typedef struct packed {logic en; logic ind; logic [7:0] addr;} bcalc_loc_t;
   typedef enum logic [1:0] {BC_AR_ADD, BC_AR_ADDWC, BC_AR_SUBWB} bcalc_arith_t;
endpackage : bcalc_pkg

// >>> hdl/bcalc_core.sv
// Execution core for arithmetic, logic and transfer instructions
`timescale 1ns/1ns
`include "bcalc_defines.svh"
module bcalc_core
   import bcalc_pkg::*;
(
   input wire logic clk, // Core clock
   input wire logic rst, // Synchronous reset
   output logic [15:0] codeAddr, // Program memory address
   input wire logic [7:0] codeData, // Program memory byte, same cycle
   output logic [15:0] xAddr, // External RAM address
   output logic [7:0] xWrData, // External RAM write data
   output logic xWe, // External RAM write pulse
   output logic xRe, // External RAM read pulse
   input wire logic [7:0] xRdData, // External RAM read data
   output logic [7:0] accOut, // Accumulator
   output logic [7:0] pswOut, // Status word
   output logic instrDone // Last cycle of an instruction
);
   logic [7:0] iram_q [0:255]; // Internal RAM, lower half also direct
   logic [7:0] specReg_q [0:127]; // Plain special registers
   logic [2:0] cycIdx_q, cycIdx_d; // Cycle within instruction
   logic [7:0] op_q, op_d; // Latched opcode
   logic [7:0] b1_q, b1_d; // Latched second byte
   logic [7:0] b2_q, b2_d; // Latched third byte
   logic [15:0] pc_q, pc_d; // Program counter
   logic [15:0] codeAddr_q, codeAddr_d; // Code address register
   logic [7:0] acc_q, acc_d; // Accumulator
   logic [7:0] b_q, b_d; // B register
   bcalc_psw_t psw_q, psw_d; // Status word
   logic [15:0] dataPtr_q, dataPtr_d; // Data pointer
   logic [15:0] xAddr_q, xAddr_d; // External address register
   logic [7:0] xWrData_q, xWrData_d; // External data register
   logic xWe_q, xWe_d; // External write strobe
   logic xRe_q, xRe_d; // External read strobe
   logic [7:0] curOp, curB1, curB2; // Bytes seen this cycle
   logic [3:0] hi, lo; // Opcode nibbles
   bcalc_timing_t opTime; // Length and cycles of current op
   logic lastCyc; // Final cycle flag
   bcalc_loc_t loc; // Operand location from low nibble
   bcalc_loc_t dst; // Write target
   logic [7:0] wData; // Write value
   logic ramWe, specRegWe; // Array write enables
   logic [7:0] wregAddr, ptrVal, srcVal; // Operand helpers
   bcalc_arith_t arKind; // Add flavour
   logic [7:0] sOp; // Second adder input
   logic cIn; // Adder carry in
   logic [8:0] sum9; // Byte sum with carry
   logic [4:0] nib5; // Nibble sum with carry
   logic [15:0] prod; // Multiply result
   logic [7:0] quo, rem; // Divide results
   logic [7:0] bitByte, bitMask; // Bit operand byte and mask
   logic [15:0] tableAddr; // Indexed code address

   // Direct space read: low half RAM, high half special registers
   function automatic logic [7:0] rdDirect(input logic [7:0] a);
      logic [7:0] v;
      v = iram_q[a];
      if (a >= `BC_ADR_HIGH)
      begin
         case (a)
            `BC_ADR_ACC: v = acc_q;
            `BC_ADR_B: v = b_q;
            `BC_ADR_PSW: v = psw_q;
            `BC_ADR_DPL: v = dataPtr_q[7:0];
            `BC_ADR_DPH: v = dataPtr_q[15:8];
            default: v = specReg_q[a[6:0]];
         endcase
      end
      return v;
   endfunction : rdDirect

   // Per-bit logic operation chosen by high nibble
   function automatic logic [7:0] logicOp(input logic [3:0] h, input logic [7:0] x, input logic [7:0] y);
      logic [7:0] r;
      r = x ^ y;
      if (h == `BC_HI_AND)
      begin
         r = x & y;
      end
      else if (h == `BC_HI_OR)
      begin
         r = x | y;
      end
      return r;
   endfunction : logicOp

   // Length in bytes and time in cycles of each opcode
   function automatic bcalc_timing_t decodeTiming(input logic [7:0] op);
      logic [3:0] h, l;
      bcalc_timing_t d;
      h = op[7:4];
      l = op[3:0];
      d = '{`BC_LEN_1, `BC_CYC_1};
      case (h)
         `BC_HI_ADD, `BC_HI_ADDWC, `BC_HI_SUBWB, `BC_HI_OR, `BC_HI_AND, `BC_HI_XOR:
         begin
            if (l == `BC_LO_IMM || l == `BC_LO_DIR)
               d = '{`BC_LEN_2, `BC_CYC_2};
            else if (l[3:1] == 3'h3)
               d = '{`BC_LEN_1, `BC_CYC_2};
            else if (l == 4'h2 && h >= `BC_HI_OR && h <= `BC_HI_XOR)
               d = '{`BC_LEN_2, `BC_CYC_3};
            else if (l == 4'h3 && h >= `BC_HI_OR && h <= `BC_HI_XOR)
               d = '{`BC_LEN_3, `BC_CYC_3};
            else if (op == `BC_OP_LDDP)
               d = '{`BC_LEN_3, `BC_CYC_3};
            else if (op == `BC_OP_TABLE)
               d = '{`BC_LEN_1, `BC_CYC_5};
         end
         `BC_HI_INC, `BC_HI_DECR:
         begin
            if (l == `BC_LO_DIR)
               d = '{`BC_LEN_2, `BC_CYC_3};
            else if (l[3:1] == 3'h3)
               d = '{`BC_LEN_1, `BC_CYC_3};
            else if (l[3])
               d = '{`BC_LEN_1, `BC_CYC_2};
         end
         `BC_HI_MOVI:
            if (l == `BC_LO_DIR)
               d = '{`BC_LEN_3, `BC_CYC_3};
            else if (l >= `BC_LO_IMM)
               d = '{`BC_LEN_2, `BC_CYC_2};
         `BC_HI_MOVD:
            if (l == `BC_LO_IMM)
               d = '{`BC_LEN_1, `BC_CYC_6};
            else if (l == `BC_LO_DIR)
               d = '{`BC_LEN_3, `BC_CYC_3};
            else if (l[3:1] == 3'h3)
               d = '{`BC_LEN_2, `BC_CYC_3};
            else if (l[3])
               d = '{`BC_LEN_2, `BC_CYC_2};
         `BC_HI_MOVR:
            if (l == `BC_LO_IMM)
               d = '{`BC_LEN_1, `BC_CYC_2};
            else if (l > `BC_LO_DIR)
               d = '{`BC_LEN_2, `BC_CYC_3};
         4'hB, 4'hC, 4'hD:
            if (l == 4'h2)
               d = '{`BC_LEN_2, `BC_CYC_3};
         `BC_HI_MOVA, `BC_HI_MOVFA:
            if (l == 4'h0)
               d = (h == `BC_HI_MOVA) ? '{`BC_LEN_1, `BC_CYC_3} : '{`BC_LEN_1, `BC_CYC_4};
            else if (l[3:1] == 3'h1)
               d = (h == `BC_HI_MOVA) ? '{`BC_LEN_1, `BC_CYC_4} : '{`BC_LEN_1, `BC_CYC_5};
            else if (l == `BC_LO_DIR)
               d = '{`BC_LEN_2, `BC_CYC_2};
            else if (l[3:1] == 3'h3)
               d = '{`BC_LEN_1, `BC_CYC_2};
         default: d = '{`BC_LEN_1, `BC_CYC_1};
      endcase
      return d;
   endfunction : decodeTiming

   // Sequencing, operand selection and execution
   always_comb
   begin
      cycIdx_d = cycIdx_q;
      op_d = op_q;
      b1_d = b1_q;
      b2_d = b2_q;
      pc_d = pc_q;
      acc_d = acc_q;
      b_d = b_q;
      psw_d = psw_q;
      dataPtr_d = dataPtr_q;
      xAddr_d = xAddr_q;
      xWrData_d = xWrData_q;
      xWe_d = 1'b0;
      xRe_d = 1'b0;
      dst = '0;
      wData = `BC_RST_BYTE;
      ramWe = 1'b0;
      specRegWe = 1'b0;
      // Bytes arrive straight from code memory in their own cycle
      curOp = (cycIdx_q == 3'h0) ? codeData : op_q;
      curB1 = (cycIdx_q == 3'h1) ? codeData : b1_q;
      curB2 = (cycIdx_q == 3'h2) ? codeData : b2_q;
      hi = curOp[7:4];
      lo = curOp[3:0];
      opTime = decodeTiming(curOp);
      lastCyc = (cycIdx_q == opTime.cyc - 3'h1);
      cycIdx_d = lastCyc ? 3'h0 : cycIdx_q + 3'h1;
      // Fetch one byte per cycle while bytes remain
      if (cycIdx_q < {1'b0, opTime.len})
      begin
         pc_d = pc_q + 16'h0001;
      end
      case (cycIdx_q)
         3'h0: op_d = codeData;
         3'h1: b1_d = codeData;
         3'h2: b2_d = codeData;
         default: op_d = op_q;
      endcase
      // Working registers of the selected bank, pointer from R0 or R1
      wregAddr = {3'b000, psw_q.rs, curOp[2:0]};
      ptrVal = iram_q[{3'b000, psw_q.rs, 2'b00, curOp[0]}];
      loc = '{1'b1, 1'b0, curB1};
      if (lo[3])
      begin
         loc.addr = wregAddr;
      end
      else if (lo[3:1] == 3'h3)
      begin
         loc = '{1'b1, 1'b1, ptrVal};
      end
      srcVal = (lo == `BC_LO_IMM) ? curB1 : (loc.ind ? iram_q[loc.addr] : rdDirect(loc.addr));
      // Shared adder; subtraction adds the complement and inverts carries
      arKind = (hi == `BC_HI_SUBWB) ? BC_AR_SUBWB : ((hi == `BC_HI_ADDWC) ? BC_AR_ADDWC : BC_AR_ADD);
      sOp = (arKind == BC_AR_SUBWB) ? ~srcVal : srcVal;
      cIn = (arKind == BC_AR_SUBWB) ? ~psw_q.cy : ((arKind == BC_AR_ADDWC) & psw_q.cy);
      sum9 = {1'b0, acc_q} + {1'b0, sOp} + {8'h00, cIn};
      nib5 = {1'b0, acc_q[3:0]} + {1'b0, sOp[3:0]} + {4'h0, cIn};
      prod = {8'h00, acc_q} * {8'h00, b_q};
      // Divide by zero leaves zeros; the result regs are then not written
      quo = (b_q == 8'h00) ? 8'h00 : acc_q / b_q;
      rem = (b_q == 8'h00) ? 8'h00 : acc_q % b_q;
      bitByte = curB1[7] ? {curB1[7:3], 3'b000} : `BC_BITRAM_BASE + {4'h0, curB1[6:3]};
      bitMask = 8'h01 << curB1[2:0];
      tableAddr = dataPtr_q + {8'h00, acc_q};
      // Code address register follows the table read while it runs
      codeAddr_d = (!lastCyc && curOp == `BC_OP_TABLE) ? tableAddr : pc_d;
      // External RAM request is set in the first cycle only and shows on the pins in the second
      if (cycIdx_q == 3'h0 && (hi == `BC_HI_MOVA || hi == `BC_HI_MOVFA) && (lo == 4'h0 || lo[3:1] == 3'h1))
      begin
         xAddr_d = lo[1] ? {8'h00, ptrVal} : dataPtr_q;
         xWrData_d = acc_q;
         xWe_d = (hi == `BC_HI_MOVFA);
         xRe_d = (hi == `BC_HI_MOVA);
      end
      // Results are committed on the final cycle
      if (lastCyc)
      begin
         case (curOp)
            `BC_OP_RR: acc_d = {acc_q[0], acc_q[7:1]};
            `BC_OP_RORC: {acc_d, psw_d.cy} = {psw_q.cy, acc_q};
            `BC_OP_RL: acc_d = {acc_q[6:0], acc_q[7]};
            `BC_OP_ROLC: {psw_d.cy, acc_d} = {acc_q, psw_q.cy};
            `BC_OP_SWAP: acc_d = {acc_q[3:0], acc_q[7:4]};
            `BC_OP_CLRA: acc_d = 8'h00;
            `BC_OP_CPLA: acc_d = ~acc_q;
            `BC_OP_INCDP: dataPtr_d = dataPtr_q + 16'h0001;
            `BC_OP_LDDP: dataPtr_d = {curB1, curB2};
            `BC_OP_TABLE: acc_d = codeData;
            `BC_OP_MOVAI: acc_d = curB1;
            `BC_OP_MULT:
            begin
               {b_d, acc_d} = prod;
               psw_d.cy = 1'b0;
               psw_d.ov = (prod[15:8] != 8'h00);
            end
            `BC_OP_DIVIDE:
            begin
               if (b_q != 8'h00)
               begin
                  acc_d = quo;
                  b_d = rem;
               end
               psw_d.cy = 1'b0;
               psw_d.ov = (b_q == 8'h00);
            end
            `BC_OP_MOVDI:
            begin
               dst = '{1'b1, 1'b0, curB1};
               wData = curB2;
            end
            `BC_OP_MOVDD:
            begin
               dst = '{1'b1, 1'b0, curB2};
               wData = rdDirect(curB1);
            end
            `BC_OP_BITCPL, `BC_OP_BITCLR, `BC_OP_BITSET:
            begin
               dst = '{1'b1, 1'b0, bitByte};
               wData = (curOp == `BC_OP_BITCPL) ? rdDirect(bitByte) ^ bitMask :
                       ((curOp == `BC_OP_BITSET) ? rdDirect(bitByte) | bitMask : rdDirect(bitByte) & ~bitMask);
            end
            default:
            begin
               case (hi)
                  `BC_HI_ADD, `BC_HI_ADDWC, `BC_HI_SUBWB:
                     if (lo >= `BC_LO_IMM)
                     begin
                        acc_d = sum9[7:0];
                        psw_d.cy = sum9[8] ^ (arKind == BC_AR_SUBWB);
                        psw_d.ac = nib5[4] ^ (arKind == BC_AR_SUBWB);
                        psw_d.ov = (acc_q[7] == sOp[7]) && (sum9[7] != acc_q[7]);
                     end
                  `BC_HI_OR, `BC_HI_AND, `BC_HI_XOR:
                     if (lo >= `BC_LO_IMM)
                     begin
                        acc_d = logicOp(hi, acc_q, srcVal);
                     end
                     else if (lo[3:1] == 3'h1)
                     begin
                        dst = '{1'b1, 1'b0, curB1};
                        wData = logicOp(hi, rdDirect(curB1), lo[0] ? curB2 : acc_q);
                     end
                  `BC_HI_INC, `BC_HI_DECR:
                     if (lo == `BC_LO_IMM)
                     begin
                        acc_d = (hi == `BC_HI_INC) ? acc_q + 8'h01 : acc_q - 8'h01;
                     end
                     else if (lo > `BC_LO_IMM)
                     begin
                        dst = loc;
                        wData = (hi == `BC_HI_INC) ? srcVal + 8'h01 : srcVal - 8'h01;
                     end
                  `BC_HI_MOVA:
                     if (lo >= `BC_LO_DIR)
                     begin
                        acc_d = srcVal;
                     end
                     else if (lo != 4'h1)
                     begin
                        acc_d = xRdData;
                     end
                  `BC_HI_MOVFA:
                     if (lo >= `BC_LO_DIR)
                     begin
                        dst = loc;
                        wData = acc_q;
                     end
                  `BC_HI_MOVI:
                     if (lo > `BC_LO_DIR)
                     begin
                        dst = loc;
                        wData = curB1;
                     end
                  `BC_HI_MOVD:
                     if (lo > `BC_LO_DIR)
                     begin
                        dst = '{1'b1, 1'b0, curB1};
                        wData = srcVal;
                     end
                  `BC_HI_MOVR:
                     if (lo > `BC_LO_DIR)
                     begin
                        dst = loc;
                        wData = rdDirect(curB1);
                     end
                  default: dst = '0;
               endcase
            end
         endcase
      end
      // Writes aimed at dedicated special registers go to their flops
      if (dst.en && !dst.ind && dst.addr >= `BC_ADR_HIGH)
      begin
         case (dst.addr)
            `BC_ADR_ACC: acc_d = wData;
            `BC_ADR_B: b_d = wData;
            `BC_ADR_PSW: psw_d = wData;
            `BC_ADR_DPL: dataPtr_d[7:0] = wData;
            `BC_ADR_DPH: dataPtr_d[15:8] = wData;
            default: specRegWe = 1'b1;
         endcase
      end
      else
      begin
         ramWe = dst.en;
      end
      psw_d.p = ^acc_d;
   end

   // State registers
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         cycIdx_q <= 3'h0;
         op_q <= `BC_RST_BYTE;
         b1_q <= `BC_RST_BYTE;
         b2_q <= `BC_RST_BYTE;
         pc_q <= `BC_RST_WORD;
         codeAddr_q <= `BC_RST_WORD;
         acc_q <= `BC_RST_BYTE;
         b_q <= `BC_RST_BYTE;
         psw_q <= `BC_RST_BYTE;
         dataPtr_q <= `BC_RST_WORD;
         xAddr_q <= `BC_RST_WORD;
         xWrData_q <= `BC_RST_BYTE;
         xWe_q <= 1'b0;
         xRe_q <= 1'b0;
      end
      else
      begin
         cycIdx_q <= cycIdx_d;
         op_q <= op_d;
         b1_q <= b1_d;
         b2_q <= b2_d;
         pc_q <= pc_d;
         codeAddr_q <= codeAddr_d;
         acc_q <= acc_d;
         b_q <= b_d;
         psw_q <= psw_d;
         dataPtr_q <= dataPtr_d;
         xAddr_q <= xAddr_d;
         xWrData_q <= xWrData_d;
         xWe_q <= xWe_d;
         xRe_q <= xRe_d;
      end
   end

   // Memory write ports; contents are not cleared by reset
   always_ff @(posedge clk)
   begin
      if (ramWe && !rst)
         iram_q[dst.addr] <= wData;
      if (specRegWe && !rst)
         specReg_q[dst.addr[6:0]] <= wData;
   end

   assign codeAddr = codeAddr_q;
   assign xAddr = xAddr_q;
   assign xWrData = xWrData_q;
   assign xWe = xWe_q;
   assign xRe = xRe_q;
   assign accOut = acc_q;
   assign pswOut = psw_q;
   assign instrDone = lastCyc;

   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   logic [7:0] accSwap;
   assign accSwap = {acc_q[3:0], acc_q[7:4]};
   a_div_six_cycles: assert property ((cycIdx_q == 3'h0 && codeData == `BC_OP_DIVIDE) |->
      !instrDone [*5] ##1 instrDone) else $error("divide not six cycles");
   a_mult_two_cycles: assert property ((cycIdx_q == 3'h0 && codeData == `BC_OP_MULT) |->
      !instrDone ##1 instrDone) else $error("multiply not two cycles");
   a_inc_direct_time: assert property ((cycIdx_q == 3'h0 && codeData == 8'h05) |->
      !instrDone [*2] ##1 instrDone) else $error("direct increment not three cycles");
   a_mult_placement: assert property ((instrDone && curOp == `BC_OP_MULT) |=>
      {b_q, acc_q} == {8'h00, $past(acc_q)} * {8'h00, $past(b_q)}) else $error("multiply result misplaced");
   a_div_placement: assert property ((instrDone && curOp == `BC_OP_DIVIDE && b_q != 8'h00) |=>
      (acc_q == $past(acc_q) / $past(b_q)) && (b_q == $past(acc_q) % $past(b_q))) else $error("divide result misplaced");
   a_add_carry_out: assert property ((instrDone && hi == `BC_HI_ADD && lo >= `BC_LO_IMM) |=>
      {psw_q.cy, acc_q} == {1'b0, $past(acc_q)} + {1'b0, $past(srcVal)}) else $error("add result or carry wrong");
   a_and_bitwise: assert property ((instrDone && hi == `BC_HI_AND && lo >= `BC_LO_IMM) |=>
      acc_q == ($past(acc_q) & $past(srcVal))) else $error("and result wrong");
   a_swap_nibbles: assert property ((instrDone && curOp == `BC_OP_SWAP) |=>
      acc_q == $past(accSwap)) else $error("nibble swap wrong");
   a_table_index: assert property ((cycIdx_q == 3'h0 && codeData == `BC_OP_TABLE) |=>
      codeAddr == $past(tableAddr) [*3]) else $error("table address not pointer plus accumulator");
   a_xdata_source: assert property (xWe |-> (xWrData == acc_q) && !xRe) else $error("external write not accumulator");
endmodule : bcalc_core

// >>> bench/bcalc_mem.sv
// Program memory and external data RAM model facing the core
`timescale 1ns/1ns
module bcalc_mem
(
   input wire logic clk, // Core clock
   input wire logic [15:0] codeAddr, // Code address
   output logic [7:0] codeData, // Code byte, same cycle
   input wire logic [15:0] xAddr, // External address
   input wire logic [7:0] xWrData, // External write data
   input wire logic xWe, // External write pulse
   input wire logic xRe, // External read pulse
   output logic [7:0] xRdData // External read data
);
   logic [7:0] rom [0:65535]; // Code store, filled by the bench
   logic [7:0] xram [0:255]; // External store, upper address bits ignored
   logic readOpen = 1'b0; // A read request is outstanding
   // Blank code reads as the no-effect opcode
   initial
   begin
      for (int i = 0; i < 65536; i++) rom[i] = 8'h00;
   end
   // Code bytes answer combinationally; table reads come through here
   assign codeData = rom[codeAddr];
   // Outside a read the data lines show the inverse, never a stale match
   assign xRdData = readOpen ? xram[xAddr[7:0]] : ~xram[xAddr[7:0]];
   // Writes land on the pulse; a read stays open until the next write request
   always @(posedge clk)
   begin
      if (xWe) xram[xAddr[7:0]] <= xWrData;
      if (xRe) readOpen <= 1'b1;
      else if (xWe) readOpen <= 1'b0;
   end
endmodule : bcalc_mem

// >>> bench/bcalc_core_bench.sv
// Self-checking bench for the byte arithmetic and logic core
`timescale 1ns/1ns
module bcalc_core_bench;
   import bcalc_pkg::*;
   logic clk = 1'b0; // Core clock
   logic rst = 1'b1; // Synchronous reset
   logic [15:0] codeAddr, xAddr; // Addresses from the core
   logic [7:0] codeData, xWrData, xRdData, accOut, pswOut; // Data paths
   logic xWe, xRe, instrDone; // Strobes
   int fails = 0; // Mismatch count
   int tests_run = 0; // Comparison count
   int cycles = 0; // Hang guard
   int pc = 0; // Load pointer
   bcalc_core i_bcalc_core (.clk(clk), .rst(rst), .codeAddr(codeAddr), .codeData(codeData), .xAddr(xAddr),
      .xWrData(xWrData), .xWe(xWe), .xRe(xRe), .xRdData(xRdData), .accOut(accOut), .pswOut(pswOut),
      .instrDone(instrDone));
   bcalc_mem i_bcalc_mem (.clk(clk), .codeAddr(codeAddr), .codeData(codeData), .xAddr(xAddr),
      .xWrData(xWrData), .xWe(xWe), .xRe(xRe), .xRdData(xRdData));
   // 25 MHz clock
   initial
   begin
      forever #20 clk = ~clk;
   end
   // Cut a hang short
   always @(posedge clk)
   begin
      cycles++;
      if (cycles > 3000)
      begin
         fails++;
         test_done();
      end
   end
   // Compare one value
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      tests_run++;
      if (got !== exp)
      begin
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
         fails++;
      end
   endtask : chk
   // Hold reset and restart loading at address zero
   task automatic start();
      @(negedge clk);
      rst = 1'b1;
      pc = 0;
   endtask : start
   // Append one code byte
   task automatic put(input logic [7:0] b);
      i_bcalc_mem.rom[pc] = b;
      pc++;
   endtask : put
   // Hold reset two more cycles, then release it while the first opcode cycle stands
   task automatic go();
      repeat (2) @(negedge clk);
      rst = 1'b0;
   endtask : go
   // Count one instruction's cycles, then judge the accumulator
   task automatic exec(input int cyc, input logic [7:0] acc);
      int n;
      n = 1;
      while (instrDone !== 1'b1 && n < 20)
      begin
         @(negedge clk);
         n++;
      end
      @(negedge clk);
      chk("cycles", cyc[15:0], n[15:0]);
      chk("accOut", {8'h00, acc}, {8'h00, accOut});
   endtask : exec
   // Immediate add, add with carry, subtract with borrow and flags
   task automatic t_arith();
      start();
      put(8'h74); put(8'h7F); put(8'h24); put(8'h01); put(8'h34); put(8'h80); put(8'h94); put(8'h01);
      go();
      exec(2, 8'h7F);
      exec(2, 8'h80);
      chk("pswOut", 16'h0045, {8'h00, pswOut});
      exec(2, 8'h00);
      chk("pswOut", 16'h0084, {8'h00, pswOut});
      exec(2, 8'hFE);
      chk("pswOut", 16'h00C1, {8'h00, pswOut});
   endtask : t_arith
   // Register, direct and indirect forms with increment, decrement and logic into memory
   task automatic t_modes();
      start();
      put(8'h78); put(8'h30); put(8'h75); put(8'h30); put(8'h11); put(8'h74); put(8'h01); put(8'h25);
      put(8'h30); put(8'h26); put(8'h28); put(8'h08); put(8'h18); put(8'h28); put(8'h05); put(8'h30);
      put(8'h25); put(8'h30); put(8'h52); put(8'h30); put(8'h25); put(8'h30);
      go();
      exec(2, 8'h00);
      exec(3, 8'h00);
      exec(2, 8'h01);
      exec(2, 8'h12);
      exec(2, 8'h23);
      exec(1, 8'h53);
      exec(2, 8'h53);
      exec(2, 8'h53);
      exec(1, 8'h83);
      exec(3, 8'h83);
      exec(2, 8'h95);
      exec(3, 8'h95);
      exec(2, 8'hA5);
   endtask : t_modes
   // Byte logic, rotates, nibble swap, complement and clear
   task automatic t_logic();
      start();
      put(8'h74); put(8'hA5); put(8'h44); put(8'h0F); put(8'h54); put(8'h3C); put(8'h64); put(8'hFF);
      put(8'h23); put(8'h03); put(8'hC4); put(8'hF4); put(8'h33); put(8'h13); put(8'hE4);
      go();
      exec(2, 8'hA5);
      exec(2, 8'hAF);
      exec(2, 8'h2C);
      exec(2, 8'hD3);
      exec(1, 8'hA7);
      exec(1, 8'hD3);
      exec(1, 8'h3D);
      exec(1, 8'hC2);
      exec(1, 8'h84);
      exec(1, 8'hC2);
      exec(1, 8'h00);
   endtask : t_logic
   // Multiply and divide with the B register
   task automatic t_muldiv();
      start();
      put(8'h74); put(8'h0A); put(8'h75); put(8'hF0); put(8'h03); put(8'hA4); put(8'h75); put(8'hF0);
      put(8'h07); put(8'h84);
      go();
      exec(2, 8'h0A);
      exec(3, 8'h0A);
      exec(2, 8'h1E);
      chk("pswOut", 16'h0000, {8'h00, pswOut});
      exec(3, 8'h1E);
      exec(6, 8'h04);
      chk("pswOut", 16'h0001, {8'h00, pswOut});
   endtask : t_muldiv
   // External moves through the pointer and R0, an indexed table read and a bit set
   task automatic t_ext();
      start();
      put(8'h90); put(8'h12); put(8'h34); put(8'h74); put(8'h5A); put(8'hF0); put(8'hE4); put(8'hE0);
      put(8'h74); put(8'h02); put(8'h93);
      put(8'h78); put(8'h40); put(8'hF2); put(8'hE4); put(8'hE2); put(8'h75); put(8'h20); put(8'h00);
      put(8'hD2); put(8'h03); put(8'hE5); put(8'h20);
      i_bcalc_mem.rom[16'h1236] = 8'hC3;
      go();
      exec(3, 8'h00);
      exec(2, 8'h5A);
      @(negedge clk);
      chk("xWe", 16'h0001, {15'h0000, xWe});
      chk("xAddr", 16'h1234, xAddr);
      chk("xWrData", 16'h005A, {8'h00, xWrData});
      exec(3, 8'h5A);
      exec(1, 8'h00);
      @(negedge clk);
      chk("xRe", 16'h0001, {15'h0000, xRe});
      exec(2, 8'h5A);
      exec(2, 8'h02);
      exec(5, 8'hC3);
      exec(2, 8'hC3);
      @(negedge clk);
      chk("xAddr", 16'h0040, xAddr);
      exec(4, 8'hC3);
      exec(1, 8'h00);
      exec(4, 8'hC3);
      exec(3, 8'hC3);
      exec(3, 8'hC3);
      exec(2, 8'h08);
   endtask : t_ext
   // Verdict and end of run
   task automatic test_done();
      if (fails == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : test_done
   // Main sequence
   initial
   begin
      t_arith();
      t_modes();
      t_logic();
      t_muldiv();
      t_ext();
      test_done();
   end
endmodule : bcalc_core_bench
